// >>> rre_defines.svh
/*
 * Shared constants of the return and rotate execution block: reset values,
 * bit positions and default widths.
 * Assumes it is included by bare name at file scope, ahead of a package or module.
 */
`ifndef RRE_DEFINES_SVH
`define RRE_DEFINES_SVH

`define RRE_DATA_W      8
`define RRE_BIT_MSB     3'h7
`define RRE_BIT_LSB     3'h0
`define RRE_PC_W        13
`define RRE_WORK_RST    8'h00
`define RRE_CARRY_RST   1'b0
`define RRE_ZERO_RST    1'b0
`define RRE_OVF_RST     1'b0
`define RRE_MIE_RST     1'b0
`define RRE_IRQ_VEC     13'h0004

`endif

// >>> rre_exec.sv
/*
 * Execution unit for the return-with-immediate, return-from-interrupt and
 * the eight-bit rotate instructions. It owns the working result register,
 * the carry, zero and overflow flags, the master interrupt enable and the PC.
 * Assumes a decoder on the same clock presents one operation per op_valid
 * pulse, with the operand byte already read from data memory and the top
 * of the return stack on stack_pc. The stack itself lives outside.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rre_defines.svh"

module rre_exec
    import rre_pkg::*;
#(
    parameter int               PC_W    = `RRE_PC_W,
    parameter logic [PC_W-1:0]  IRQ_VEC = `RRE_IRQ_VEC
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            op_valid,
    input  wire rre_op_t         op_code,
    input  wire logic [7:0]      mem_rd_data,
    input  wire logic [7:0]      imm_data,
    input  wire logic [PC_W-1:0] stack_pc,
    input  wire logic            irq_pending,
    input  wire logic            mie_wr_en,
    input  wire logic            mie_wr_val,
    output logic      [7:0]      work_reg,
    output logic                 carry_flag,
    output logic                 zero_flag,
    output logic                 ovf_flag,
    output logic                 master_interrupt_enable,
    output logic      [PC_W-1:0] pc,
    output logic                 stack_pop,
    output logic                 mem_wr_en,
    output logic      [7:0]      mem_wr_data,
    output logic                 irq_enter,
    output logic      [PC_W-1:0] irq_ret_addr,
    output logic                 op_done
);

    // The counter must hold the interrupt vector; wider than 16 bits is not served.
    if (PC_W < 3 || PC_W > 16) begin : g_pc_w_check
        $error("PC_W out of range");
    end

    typedef struct packed {
        logic [7:0]      work;
        logic            c;
        logic            z;
        logic            ov;
        logic            mie;
        logic [PC_W-1:0] pc;
        logic            pop;
        logic            we;
        logic [7:0]      wdata;
        logic            irq;
        logic [PC_W-1:0] ret;
        logic            done;
    } rre_state_t;

    rre_state_t s_r;
    rre_state_t s_nxt;
    logic [7:0] rot_res;
    logic       rot_c;
    logic       rot_right;
    logic       rot_thru;

    ////////////////////////////////////////////////////////////////////////
    // Direction and carry mode follow straight from the operation code.
    assign rot_right = (op_code == OP_ROTATE_RIGHT_IN_PLACE) ||
                       (op_code == OP_ROTATE_RIGHT_TO_WORK_REG) ||
                       (op_code == OP_ROTATE_RIGHT_THROUGH_CARRY);
    assign rot_thru  = (op_code == OP_ROTATE_LEFT_THROUGH_CARRY) ||
                       (op_code == OP_ROTATE_LEFT_CARRY_TO_WORK_REG) ||
                       (op_code == OP_ROTATE_RIGHT_THROUGH_CARRY);

    rre_rotator u_rot (
        .src        (mem_rd_data),
        .carry_in   (s_r.c),
        .dir_right  (rot_right),
        .thru_carry (rot_thru),
        .result     (rot_res),
        .carry_out  (rot_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state. Pulses default low; zero and overflow are never touched here.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.pop  = 1'b0;
        s_nxt.we   = 1'b0;
        s_nxt.irq  = 1'b0;
        s_nxt.done = 1'b0;
        // A core write to the enable yields to a return from interrupt in the same cycle.
        if (mie_wr_en) begin
            s_nxt.mie = mie_wr_val;
        end
        if (op_valid) begin
            s_nxt.done = 1'b1;
            unique case (op_code)
                OP_RET_IMM: begin
                    s_nxt.pc  = stack_pc;
                    s_nxt.pop = 1'b1;
                    s_nxt.work = imm_data;
                end
                OP_RETURN_FROM_INTERRUPT: begin
                    s_nxt.pop = 1'b1;
                    if (irq_pending) begin
                        // Chain straight into the handler; the popped address is
                        // handed back so the main program resumes afterwards.
                        s_nxt.irq = 1'b1;
                        s_nxt.ret = stack_pc;
                        s_nxt.pc  = IRQ_VEC;
                        s_nxt.mie = 1'b0;
                    end else begin
                        s_nxt.pc  = stack_pc;
                        s_nxt.mie = 1'b1;
                    end
                end
                OP_ROTATE_LEFT_IN_PLACE, OP_ROTATE_RIGHT_IN_PLACE: begin
                    s_nxt.we    = 1'b1;
                    s_nxt.wdata = rot_res;
                end
                OP_ROTATE_LEFT_TO_WORK_REG, OP_ROTATE_RIGHT_TO_WORK_REG: begin
                    s_nxt.work = rot_res;
                end
                OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                    s_nxt.we    = 1'b1;
                    s_nxt.wdata = rot_res;
                    s_nxt.c     = rot_c;
                end
                OP_ROTATE_LEFT_CARRY_TO_WORK_REG: begin
                    s_nxt.work = rot_res;
                    s_nxt.c   = rot_c;
                end
                OP_NONE: begin
                    s_nxt.done = 1'b0;
                end
                default: begin
                    s_nxt.done = 1'b0;  // Illegal codes are ignored.
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r       <= '0;
            s_r.work  <= `RRE_WORK_RST;
            s_r.c     <= `RRE_CARRY_RST;
            s_r.z     <= `RRE_ZERO_RST;
            s_r.ov    <= `RRE_OVF_RST;
            s_r.mie   <= `RRE_MIE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign work_reg                = s_r.work;
    assign carry_flag              = s_r.c;
    assign zero_flag               = s_r.z;
    assign ovf_flag                = s_r.ov;
    assign master_interrupt_enable = s_r.mie;
    assign pc                      = s_r.pc;
    assign stack_pop               = s_r.pop;
    assign mem_wr_en               = s_r.we;
    assign mem_wr_data             = s_r.wdata;
    assign irq_enter               = s_r.irq;
    assign irq_ret_addr            = s_r.ret;
    assign op_done                 = s_r.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_issue(rre_op_t o);
        op_valid && op_code == o;
    endsequence

    sequence s_ret_int_quiet;
        s_issue(OP_RETURN_FROM_INTERRUPT) ##0 !irq_pending;
    endsequence

    AST_RET_IMM: assert property (s_issue(OP_RET_IMM) |=> stack_pop && pc == $past(stack_pc)
        && work_reg == $past(imm_data) && carry_flag == $past(carry_flag))
        else $error("return with immediate wrong");
    AST_RET_INT: assert property (s_ret_int_quiet |=> master_interrupt_enable && stack_pop
        && pc == $past(stack_pc) && !irq_enter && $stable(carry_flag))
        else $error("return from interrupt wrong");
    AST_RET_INT_CHAIN: assert property (s_issue(OP_RETURN_FROM_INTERRUPT) ##0 irq_pending
        |=> irq_enter && pc == IRQ_VEC && irq_ret_addr == $past(stack_pc))
        else $error("pending interrupt not chained");
    AST_ROL_MEM: assert property (s_issue(OP_ROTATE_LEFT_IN_PLACE) |=> mem_wr_en
        && mem_wr_data == {$past(mem_rd_data[6:0]), $past(mem_rd_data[7])}
        && $stable(carry_flag))
        else $error("rotate left in place wrong");
    AST_ROL_WORK: assert property (s_issue(OP_ROTATE_LEFT_TO_WORK_REG) |=> !mem_wr_en
        && work_reg == {$past(mem_rd_data[6:0]), $past(mem_rd_data[7])}
        && $stable(carry_flag))
        else $error("rotate left to work reg wrong");
    AST_ROL_CARRY_MEM: assert property (s_issue(OP_ROTATE_LEFT_THROUGH_CARRY) |=> mem_wr_en
        && mem_wr_data == {$past(mem_rd_data[6:0]), $past(carry_flag)}
        && carry_flag == $past(mem_rd_data[7]))
        else $error("rotate left through carry wrong");
    AST_ROL_CARRY_WORK: assert property (s_issue(OP_ROTATE_LEFT_CARRY_TO_WORK_REG) |=> !mem_wr_en
        && work_reg == {$past(mem_rd_data[6:0]), $past(carry_flag)}
        && carry_flag == $past(mem_rd_data[7]))
        else $error("rotate left carry to work reg wrong");
    AST_ROR_MEM: assert property (s_issue(OP_ROTATE_RIGHT_IN_PLACE) |=> mem_wr_en
        && mem_wr_data == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])}
        && $stable(carry_flag))
        else $error("rotate right in place wrong");
    AST_ROR_WORK: assert property (s_issue(OP_ROTATE_RIGHT_TO_WORK_REG) |=> !mem_wr_en
        && work_reg == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])}
        && $stable(carry_flag))
        else $error("rotate right to work reg wrong");
    AST_ROR_CARRY_MEM: assert property (s_issue(OP_ROTATE_RIGHT_THROUGH_CARRY) |=> mem_wr_en
        && mem_wr_data == {$past(carry_flag), $past(mem_rd_data[7:1])}
        && carry_flag == $past(mem_rd_data[0]))
        else $error("rotate right through carry wrong");
    AST_FLAGS: assert property ($stable(zero_flag) && $stable(ovf_flag))
        else $error("zero or overflow flag changed");

endmodule

`default_nettype wire

// >>> rre_exec_bench.sv
/*
 * Self-checking bench for the return and rotate execution unit: an integer
 * model predicts every result, which is compared one cycle after each op.
 * Assumes rre_pkg and rre_exec are compiled first; the bench plays the core.
 */
`timescale 1ns/1ps
`default_nettype none

`define RRE_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module rre_exec_bench
    import rre_pkg::*;
;

    localparam int              PC_W    = 13;
    localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;

    logic            clk, sys_rst, op_valid, irq_pending, mie_wr_en, mie_wr_val;
    rre_op_t         op_code;
    logic [7:0]      mem_rd_data, imm_data, work_reg, mem_wr_data;
    logic [PC_W-1:0] stack_pc, pc, irq_ret_addr;
    logic            carry_flag, zero_flag, ovf_flag, master_interrupt_enable;
    logic            stack_pop, mem_wr_en, irq_enter, op_done;
    int              miscompares, n_tests;
    int              m_work, m_carry, m_mie, m_pc, m_wdata, m_ret;
    bit              e_done, e_pop, e_wr, e_irq, chk_pc;
    logic [15:0]     lfsr_r;
    int              pat[$] = '{8'h81, 8'h01, 8'h80, 8'h7E, 8'h00, 8'hFF};

    rre_exec #(.PC_W(PC_W), .IRQ_VEC(IRQ_VEC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
        .mem_rd_data(mem_rd_data), .imm_data(imm_data), .stack_pc(stack_pc),
        .irq_pending(irq_pending), .mie_wr_en(mie_wr_en), .mie_wr_val(mie_wr_val),
        .work_reg(work_reg), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .ovf_flag(ovf_flag), .master_interrupt_enable(master_interrupt_enable),
        .pc(pc), .stack_pop(stack_pop), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .irq_enter(irq_enter),
        .irq_ret_addr(irq_ret_addr), .op_done(op_done));

    ////////////////////////////////////////////////////////////////////////////
    // Clock of 5 ns and a watchdog sized well above the roughly 700 cycles used.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #(5 * 4000);
        miscompares++;
        finish_test();
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Compares what the design shows against the model for the op taken last.
    task automatic check_outputs();
        `RRE_CHK(op_done, e_done)
        `RRE_CHK(stack_pop, e_pop)
        `RRE_CHK(work_reg, m_work[7:0])
        `RRE_CHK(carry_flag, m_carry[0])
        `RRE_CHK({zero_flag, ovf_flag}, 2'h0)
        `RRE_CHK(master_interrupt_enable, m_mie[0])
        `RRE_CHK(mem_wr_en, e_wr)
        `RRE_CHK(irq_enter, e_irq)
        if (e_wr) `RRE_CHK(mem_wr_data, m_wdata[7:0])
        if (chk_pc) `RRE_CHK(pc, m_pc[PC_W-1:0])
        if (e_irq) `RRE_CHK(irq_ret_addr, m_ret[PC_W-1:0])
    endtask

    // Checks the previous op, then predicts and drives the next one at negedge.
    task automatic apply(input bit v, input int code, input int mem, input int imm,
                         input int spc, input bit irq, input bit mw, input bit mwv);
        check_outputs();
        {e_done, e_pop, e_wr, e_irq, chk_pc} = 5'h00;
        if (mw) m_mie = mwv;
        if (v && code >= 1 && code <= 9) e_done = 1'b1;
        if (v) case (code)
            1: begin m_pc = spc; m_work = imm; e_pop = 1; chk_pc = 1; end
            2: begin
                m_pc = irq ? IRQ_VEC : spc; m_mie = !irq; m_ret = spc;
                e_irq = irq; e_pop = 1; chk_pc = 1;
            end
            3: begin m_wdata = ((mem << 1) | (mem >> 7)) & 8'hFF; e_wr = 1; end
            4: m_work = ((mem << 1) | (mem >> 7)) & 8'hFF;
            5: begin m_wdata = ((mem << 1) | m_carry) & 8'hFF; m_carry = mem >> 7; e_wr = 1; end
            6: begin m_work = ((mem << 1) | m_carry) & 8'hFF; m_carry = mem >> 7; end
            7: begin m_wdata = (mem >> 1) | ((mem & 1) << 7); e_wr = 1; end
            8: m_work = (mem >> 1) | ((mem & 1) << 7);
            9: begin m_wdata = (mem >> 1) | (m_carry << 7); m_carry = mem & 1; e_wr = 1; end
            default: ;
        endcase
        op_valid    = v;
        op_code     = rre_op_t'(code[3:0]);
        mem_rd_data = mem[7:0];
        imm_data    = imm[7:0];
        stack_pc    = spc[PC_W-1:0];
        irq_pending = irq;
        mie_wr_en   = mw;
        mie_wr_val  = mwv;
        @(negedge clk);
    endtask

    // Holds reset for n cycles; all results and the model's work, carry, enable and PC return to zero.
    task automatic do_reset(input int n);
        sys_rst  = 1'b1;
        op_valid = 1'b0;
        repeat (n) @(negedge clk);
        {m_work, m_carry, m_mie, m_pc} = {4{32'h0}};
        {e_done, e_pop, e_wr, e_irq, chk_pc} = 5'h01;
        check_outputs();
        chk_pc  = 1'b0;
        sys_rst = 1'b0;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Directed boundary bytes back to back, refused codes, then random traffic
    // with a second reset in mid-run to catch state that survives reset.
    initial begin
        // Reset is raised at time zero so no edge ever sees an unknown reset.
        sys_rst     = 1'b1;
        {op_valid, irq_pending, mie_wr_en, mie_wr_val} = 4'h0;
        op_code     = OP_NONE;
        mem_rd_data = 8'h00;
        imm_data    = 8'h00;
        stack_pc    = 13'h0000;
        lfsr_r      = 16'h001F;
        @(negedge clk);
        do_reset(9);
        foreach (pat[i])
            for (int k = 1; k <= 9; k++)
                apply(1, k, pat[i], pat[i] ^ 8'h5A, pat[i] * 37 + k, i % 2, 0, 0);
        $display("test directed done");
        for (int k = 10; k < 16; k++)
            apply(1, k, 8'hFF, 8'hA5, 13'h1FFF, 1, k % 2, k % 3 == 0);
        apply(1, 0, 8'h81, 8'h11, 13'h0123, 0, 0, 0);
        apply(0, 1, 8'h81, 8'h22, 13'h0456, 1, 0, 0);
        apply(1, 2, 8'h00, 8'h00, 13'h0789, 0, 1, 0);
        $display("test refused done");
        for (int n = 0; n < 600; n++) begin
            lfsr_r = lfsr_next(lfsr_r);
            apply(lfsr_r[0] | lfsr_r[1], lfsr_r[5:2] % 11, lfsr_r[15:8], lfsr_r[7:0],
                  lfsr_r[12:0] ^ 13'h0A5A, lfsr_r[6], lfsr_r[14] & lfsr_r[3], lfsr_r[9]);
            if (n == 300) do_reset(2);
        end
        check_outputs();
        $display("test random done");
        finish_test();
    end
endmodule

`default_nettype wire

// >>> rre_pkg.sv
/*
 * Types of the return and rotate execution block.
 * Assumes rre_defines.svh is reachable on the include path.
 */
`include "rre_defines.svh"

package rre_pkg;

    // Operations this block executes; everything else is another unit's job.
    typedef enum logic [3:0] {
        OP_NONE,
        OP_RET_IMM,
        OP_RETURN_FROM_INTERRUPT,
        OP_ROTATE_LEFT_IN_PLACE,
        OP_ROTATE_LEFT_TO_WORK_REG,
        OP_ROTATE_LEFT_THROUGH_CARRY,
        OP_ROTATE_LEFT_CARRY_TO_WORK_REG,
        OP_ROTATE_RIGHT_IN_PLACE,
        OP_ROTATE_RIGHT_TO_WORK_REG,
        OP_ROTATE_RIGHT_THROUGH_CARRY
    } rre_op_t;

endpackage

// >>> rre_rotator.sv
/*
 * Eight-bit one-place rotator, plain or through carry, left or right.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rre_defines.svh"

module rre_rotator (
    input  wire logic [7:0] src,
    input  wire logic       carry_in,
    input  wire logic       dir_right,
    input  wire logic       thru_carry,
    output logic      [7:0] result,
    output logic            carry_out
);

    ////////////////////////////////////////////////////////////////////////
    // The fill bit is either the old carry or the bit falling off the far end.
    always_comb begin
        logic fill_bit;
        fill_bit = 1'b0;
        if (dir_right) begin
            fill_bit  = thru_carry ? carry_in : src[`RRE_BIT_LSB];
            result    = {fill_bit, src[7:1]};
            carry_out = thru_carry ? src[`RRE_BIT_LSB] : carry_in;
        end else begin
            fill_bit  = thru_carry ? carry_in : src[`RRE_BIT_MSB];
            result    = {src[6:0], fill_bit};
            carry_out = thru_carry ? src[`RRE_BIT_MSB] : carry_in;
        end
    end

endmodule

`default_nettype wire
